// >>> shared/fss_defines.vh
// constants for the fault and start-up sequencer
`ifndef FSS_DEFINES_VH
`define FSS_DEFINES_VH
// register offsets (byte addresses)
`define FSS_ADDR_CTRL 12'h000
`define FSS_ADDR_STATUS 12'h004
`define FSS_ADDR_FAULT 12'h008
// control bits
`define FSS_CTRL_MEMCHK_OK 0
`define FSS_CTRL_MEMCHK_DONE 1
// timing
`define FSS_CLK_HZ 100000000
`define FSS_LONG_MS 1000
`define FSS_SHORT_MS 100
`define FSS_MODE_READ_MS 10
`define FSS_CYC_PER_MS (`FSS_CLK_HZ / 1000)
`define FSS_CNT_W 27
// states
`define FSS_ST_W 3
`define FSS_ST_POR 3'h0
`define FSS_ST_MODEREAD 3'h1
`define FSS_ST_SBCHARGE 3'h2
`define FSS_ST_RUN 3'h3
`define FSS_ST_FAULTWAIT 3'h4
`define FSS_ST_LATCHED 3'h5
`define FSS_ST_UVWAIT 3'h6
// fault classes
`define FSS_CLS_NONE 2'h0
`define FSS_CLS_SHORT 2'h1
`define FSS_CLS_LONG 2'h2
`define FSS_CLS_LATCH 2'h3
`endif

// >>> verilog/fss_sync_bank.v
// bank of two-flop synchronisers for the comparator inputs
`timescale 1ns/1ns
module fss_sync_bank
#(
   parameter WIDTH = 16
)
(
   // clock and reset
   input wire sys_clk,
   input wire rst_b,
   // raw and synchronised levels
   input wire [WIDTH-1:0] asyncIn,
   output wire [WIDTH-1:0] syncOut
);

   reg [WIDTH-1:0] stage1Reg;
   reg [WIDTH-1:0] stage2Reg;

   // first stage read only by second stage
   always @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         stage1Reg <= {WIDTH{1'b0}};
         stage2Reg <= {WIDTH{1'b0}};
      end
      else
      begin
         stage1Reg <= asyncIn;
         stage2Reg <= stage1Reg;
      end
   end

   assign syncOut = stage2Reg;

endmodule

// >>> verilog/fss_sequencer.v
// fault timing and start-up sequencing with apb register slave
//
// The APB interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`include "fss_defines.vh"
// Functional notes
// - junction over-temperature stops both stages at once
// - after over-temperature wait for restart temperature, then full restart if allowed
// - over-temperature is a long fault, at least one second before restart
// - three fault classes: latching, long 1 s, short 100 ms
// - latched fault holds stages off until supply is cycled
// - at turn-on bulk below line peak latches a fault, ignored while running
// - memory check failure at start-up stops everything permanently
// - resonant overcurrent, second current limit, x-cap discharge, over-temperature are long
// - supply undervoltage, brownout, line overvoltage are short faults
// - aux mode allows off, correction only, both; self-bias ignores on/off
// - aux mode chosen when pin stays low past the mode-read interval
// - after mode read, pin level selects correction only or both stages
// - at start threshold gate goes low; pin high enters self-bias, gate high
// - self-bias start level turns gate off; correction needs line current and bulk ok (aux-mode start checks bulk only, not line current)
// - self-bias keeps both stages running while supply above stop level
// - supply below mode-specific stop level stops both stages
// - aux undervoltage waits for supply above aux stop level, then restarts
// - self-bias undervoltage turns gate on, restarts at self-bias start level
module fss_sequencer
#(
   parameter LONG_CYCLES = `FSS_LONG_MS * `FSS_CYC_PER_MS,
   parameter SHORT_CYCLES = `FSS_SHORT_MS * `FSS_CYC_PER_MS,
   parameter MODE_READ_CYCLES = `FSS_MODE_READ_MS * `FSS_CYC_PER_MS
)
(
   // clock and reset
   input wire sys_clk,
   input wire rst_b,
   // apb slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // supply comparators
   input wire supplyStart,
   input wire selfbiasStartLevel,
   input wire selfbiasStopLevel,
   input wire auxbiasStopLevel,
   // mode pin comparators
   input wire modeSelectHigh,
   input wire correctionRunThreshold,
   input wire dualRunThreshold,
   // line and bulk comparators
   input wire lineCurrentRisingThreshold,
   input wire brownoutFallingLevel,
   input wire lineOverRisingLevel,
   input wire bulkBelowPeak,
   // fault sources
   input wire shutdownTemperature,
   input wire restartTemperature,
   input wire resonantOvercurrent,
   input wire correctionLimit2,
   input wire xcapDischargeDone,
   // outputs
   output reg correctionStageEn,
   output reg resonantStageEn,
   output reg startupTransistorGate,
   output reg selfBiasMode
);

   wire [12:0] syncIn;
   wire sStart, sSbStart, sSbStop, sAbStop, sModeHi, sPfcRun, sDualRun;
   wire sIac, sBrown, sOver, sBulkLow, sHot, sCool, sOcp, sLim2, sXcap;

   // every comparator lives off the clock domain
   fss_sync_bank #(.WIDTH(13)) uSync
   (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .asyncIn({supplyStart, selfbiasStartLevel, selfbiasStopLevel, auxbiasStopLevel,
         modeSelectHigh, correctionRunThreshold, dualRunThreshold,
         lineCurrentRisingThreshold, brownoutFallingLevel, lineOverRisingLevel,
         resonantOvercurrent, correctionLimit2, xcapDischargeDone}),
      .syncOut(syncIn)
   );
   assign {sStart, sSbStart, sSbStop, sAbStop, sModeHi, sPfcRun, sDualRun,
      sIac, sBrown, sOver, sOcp, sLim2, sXcap} = syncIn;

   wire [2:0] syncB;
   fss_sync_bank #(.WIDTH(3)) uSyncB
   (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .asyncIn({bulkBelowPeak, shutdownTemperature, restartTemperature}),
      .syncOut(syncB)
   );
   assign {sBulkLow, sHot, sCool} = syncB;

   reg [`FSS_ST_W-1:0] stateReg;
   reg [`FSS_ST_W-1:0] stateNext;
   reg [`FSS_CNT_W-1:0] cntReg;
   reg [`FSS_CNT_W-1:0] cntNext;
   reg [1:0] classReg;
   reg [1:0] classNext;
   reg sbReg;
   reg sbNext;
   reg gateNext;
   reg pfcNext;
   reg llcNext;
   reg hotSeenReg;
   reg hotSeenNext;
   reg memOkReg;
   reg memDoneReg;
   reg [3:0] faultSrcReg;

   // fault classification; latch beats long beats short
   wire supplyUv = sbReg ? !sSbStop : !sAbStop;
   wire longFault = sOcp | sLim2 | sXcap | sHot;
   wire shortFault = supplyUv | sBrown | sOver;
   wire memFail = memDoneReg & !memOkReg;
   wire [1:0] runClass = memFail ? `FSS_CLS_LATCH :
      longFault ? `FSS_CLS_LONG :
      shortFault ? `FSS_CLS_SHORT : `FSS_CLS_NONE;

   // stage requests per mode
   wire wantPfc = sbReg ? 1'b1 : sPfcRun;
   wire wantLlc = sbReg ? 1'b1 : sDualRun;
   wire startOk = sIac & !sBulkLow;

   // sequencer
   always @*
   begin
      stateNext = stateReg;
      cntNext = cntReg;
      classNext = classReg;
      sbNext = sbReg;
      gateNext = startupTransistorGate;
      pfcNext = 1'b0;
      llcNext = 1'b0;
      hotSeenNext = hotSeenReg | sHot;
      case (stateReg)
         `FSS_ST_POR:
         begin
            gateNext = 1'b1;
            cntNext = {`FSS_CNT_W{1'b0}};
            if (memFail)
            begin
               stateNext = `FSS_ST_LATCHED;
               classNext = `FSS_CLS_LATCH;
            end
            else if (sStart && memDoneReg)
            begin
               gateNext = 1'b0;
               stateNext = `FSS_ST_MODEREAD;
            end
         end
         `FSS_ST_MODEREAD:
         begin
            gateNext = 1'b0;
            if (sModeHi)
            begin
               sbNext = 1'b1;
               gateNext = 1'b1;
               stateNext = `FSS_ST_SBCHARGE;
            end
            else if (cntReg >= MODE_READ_CYCLES[`FSS_CNT_W-1:0])
            begin
               sbNext = 1'b0;
               stateNext = `FSS_ST_UVWAIT;
            end
            else
               cntNext = cntReg + 1'b1;
         end
         `FSS_ST_SBCHARGE:
         begin
            gateNext = 1'b1;
            if (sSbStart)
            begin
               gateNext = 1'b0;
               if (sBulkLow)
               begin
                  stateNext = `FSS_ST_LATCHED;
                  classNext = `FSS_CLS_LATCH;
               end
               else if (startOk && runClass == `FSS_CLS_NONE)
                  stateNext = `FSS_ST_RUN;
            end
         end
         `FSS_ST_UVWAIT:
         begin
            // aux mode: wait for rail, then check bulk at turn-on
            if (sAbStop && (sPfcRun || sDualRun))
            begin
               if (sBulkLow)
               begin
                  stateNext = `FSS_ST_LATCHED;
                  classNext = `FSS_CLS_LATCH;
               end
               else if (runClass == `FSS_CLS_NONE)
                  stateNext = `FSS_ST_RUN;
            end
         end
         `FSS_ST_RUN:
         begin
            // bulk check deliberately not evaluated here
            pfcNext = wantPfc;
            llcNext = wantLlc;
            if (runClass != `FSS_CLS_NONE)
            begin
               pfcNext = 1'b0;
               llcNext = 1'b0;
               classNext = runClass;
               cntNext = {`FSS_CNT_W{1'b0}};
               hotSeenNext = sHot;
               if (runClass == `FSS_CLS_LATCH)
                  stateNext = `FSS_ST_LATCHED;
               else
                  stateNext = `FSS_ST_FAULTWAIT;
            end
         end
         `FSS_ST_FAULTWAIT:
         begin
            // long overrides short if it appears while waiting
            if (longFault && classReg == `FSS_CLS_SHORT)
               classNext = `FSS_CLS_LONG;
            if (cntReg < LONG_CYCLES[`FSS_CNT_W-1:0])
               cntNext = cntReg + 1'b1;
            if (((classReg == `FSS_CLS_LONG &&
               cntReg >= LONG_CYCLES[`FSS_CNT_W-1:0]) ||
               (classReg == `FSS_CLS_SHORT &&
               cntReg >= SHORT_CYCLES[`FSS_CNT_W-1:0])) &&
               (!hotSeenReg || sCool))
            begin
               hotSeenNext = 1'b0;
               cntNext = {`FSS_CNT_W{1'b0}};
               if (sbReg)
               begin
                  gateNext = 1'b1;
                  stateNext = `FSS_ST_SBCHARGE;
               end
               else
                  stateNext = `FSS_ST_UVWAIT;
            end
         end
         `FSS_ST_LATCHED:
         begin
            // only power-on reset leaves here
            gateNext = 1'b0;
         end
         default:
         begin
            stateNext = `FSS_ST_LATCHED;
            classNext = `FSS_CLS_LATCH;
         end
      endcase
   end

   // state and outputs
   always @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         stateReg <= `FSS_ST_POR;
         cntReg <= {`FSS_CNT_W{1'b0}};
         classReg <= `FSS_CLS_NONE;
         sbReg <= 1'b0;
         hotSeenReg <= 1'b0;
         startupTransistorGate <= 1'b1;
         correctionStageEn <= 1'b0;
         resonantStageEn <= 1'b0;
         selfBiasMode <= 1'b0;
         faultSrcReg <= 4'h0;
      end
      else
      begin
         stateReg <= stateNext;
         cntReg <= cntNext;
         classReg <= classNext;
         sbReg <= sbNext;
         hotSeenReg <= hotSeenNext;
         startupTransistorGate <= gateNext;
         correctionStageEn <= pfcNext;
         resonantStageEn <= llcNext & pfcNext;
         selfBiasMode <= sbNext;
         // sticky record; a new event wins over a clear in the same cycle
         faultSrcReg <= (faultSrcReg & ~((psel && penable && pwrite &&
            paddr == `FSS_ADDR_FAULT) ? pwdata[3:0] : 4'h0)) |
            {shortFault, sHot, longFault, memFail};
      end
   end

   // apb writes land in the access phase, at the edge the master completes them
   wire apbWrite = psel & penable & pwrite;

   // memory-check result, write-once so a later write cannot undo a failure
   always @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         memOkReg <= 1'b0;
         memDoneReg <= 1'b0;
      end
      else if (apbWrite && paddr == `FSS_ADDR_CTRL && !memDoneReg)
      begin
         memOkReg <= pwdata[`FSS_CTRL_MEMCHK_OK];
         memDoneReg <= pwdata[`FSS_CTRL_MEMCHK_DONE];
      end
   end

   // apb slave, zero wait states; read data decoded in the setup cycle
   always @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= psel & !penable;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
         if (psel && !penable)
         begin
            case (paddr)
               `FSS_ADDR_CTRL:
               begin
                  prdata <= {30'h0, memDoneReg, memOkReg};
               end
               `FSS_ADDR_STATUS:
                  prdata <= {22'h0, classReg, sbReg, startupTransistorGate,
                     resonantStageEn, correctionStageEn, 1'b0, stateReg};
               `FSS_ADDR_FAULT:
                  prdata <= {28'h0, faultSrcReg};
               default:
                  pslverr <= 1'b1;
            endcase
         end
      end
   end

endmodule

// >>> tb/fss_seq_assertions.sv
// port assertions for the sequencer
`timescale 1ns/1ns
module fss_seq_assertions
(
   // clock and reset
   input wire sys_clk,
   input wire rst_b,
   // apb
   input wire psel,
   input wire penable,
   input wire pready,
   input wire pslverr,
   // comparators
   input wire shutdownTemperature,
   input wire brownoutFallingLevel,
   input wire auxbiasStopLevel,
   input wire selfbiasStopLevel,
   input wire dualRunThreshold,
   // outputs
   input wire correctionStageEn,
   input wire resonantStageEn,
   input wire startupTransistorGate,
   input wire selfBiasMode
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   // sync plus output register gives the stop margin
   sequence stopSoon;
      ##[1:4] !correctionStageEn && !resonantStageEn;
   endsequence
   sequence pinLowAux;
      (!dualRunThreshold && !selfBiasMode) [*5];
   endsequence
   chk_apb_answer: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   chk_err_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   chk_hot_stop: assert property ($rose(shutdownTemperature) |-> stopSoon)
      else $error("stages run on when hot");
   chk_brown_stop: assert property ($rose(brownoutFallingLevel) |-> stopSoon)
      else $error("stages run on in brownout");
   chk_aux_uv: assert property ($fell(auxbiasStopLevel) && !selfBiasMode |-> stopSoon)
      else $error("aux undervoltage ignored");
   chk_sb_uv: assert property ($fell(selfbiasStopLevel) && selfBiasMode |-> stopSoon)
      else $error("self-bias undervoltage ignored");
   chk_pin_low: assert property (pinLowAux |-> !resonantStageEn)
      else $error("resonant stage on below dual level");
   chk_stage_pair: assert property (resonantStageEn |-> correctionStageEn)
      else $error("resonant stage alone");
   chk_gate_mode: assert property ($rose(selfBiasMode) |-> ##[0:2] startupTransistorGate)
      else $error("gate not on entering self-bias");
   chk_gate_run: assert property (correctionStageEn |-> !startupTransistorGate)
      else $error("gate on while running");
endmodule
bind fss_sequencer fss_seq_assertions chk (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel),
   .penable(penable), .pready(pready), .pslverr(pslverr),
   .shutdownTemperature(shutdownTemperature), .brownoutFallingLevel(brownoutFallingLevel),
   .auxbiasStopLevel(auxbiasStopLevel), .selfbiasStopLevel(selfbiasStopLevel),
   .dualRunThreshold(dualRunThreshold), .correctionStageEn(correctionStageEn),
   .resonantStageEn(resonantStageEn), .startupTransistorGate(startupTransistorGate),
   .selfBiasMode(selfBiasMode));

// >>> tb/fss_power_partner.sv
// power-on controller driving the mode pin levels
`timescale 1ns/1ns
module fss_power_partner
#(
   parameter HOLD_CYCLES = 15
)
(
   // clock and reset
   input wire sys_clk,
   input wire rst_b,
   // bench requests
   input wire supplyUp,
   input wire tiedHigh,
   input wire [1:0] runLevel,
   // pin comparator levels
   output wire modeSelectHigh,
   output wire correctionRunThreshold,
   output wire dualRunThreshold
);
   reg [7:0] holdCnt;
   wire pinFree;
   // pin held low past the mode read, else aux mode is lost
   always @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b || !supplyUp)
         holdCnt <= 8'h00;
      else if (holdCnt != HOLD_CYCLES)
         holdCnt <= holdCnt + 8'h01;
   end
   // tied pin sits at supply, so every level reads high
   assign pinFree = supplyUp && holdCnt == HOLD_CYCLES;
   assign modeSelectHigh = tiedHigh && supplyUp;
   assign correctionRunThreshold = tiedHigh || (pinFree && runLevel != 2'h0);
   assign dualRunThreshold = tiedHigh || (pinFree && runLevel == 2'h2);
endmodule

// >>> tb/fault_and_startup_sequencer_test.sv
// self-checking bench for the sequencer
`timescale 1ns/1ns
`include "fss_defines.vh"
`define CHK(n, e, a) begin numChecks++; if ((a) !== (e)) begin miscompares++; \
 $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module fault_and_startup_sequencer_test;
   localparam int LG = 200;
   localparam int SH = 20;
   int miscompares = 0;
   int numChecks = 0;
   int k;
   logic [32:0] q[$];
   logic [32:0] ex;
   logic sys_clk, rst_b, psel, penable, pwrite, pready, pslverr, tiedHigh;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [1:0] runLevel;
   logic [5:0] flt;
   logic supplyStart, selfbiasStartLevel, selfbiasStopLevel, auxbiasStopLevel;
   logic lineCurrentRisingThreshold, bulkBelowPeak, restartTemperature;
   logic correctionStageEn, resonantStageEn, startupTransistorGate, selfBiasMode;
   wire modeSelectHigh, correctionRunThreshold, dualRunThreshold;
   wire shutdownTemperature, lineOverRisingLevel, brownoutFallingLevel;
   wire xcapDischargeDone, correctionLimit2, resonantOvercurrent;
   // fault sources as one vector
   assign {shutdownTemperature, lineOverRisingLevel, brownoutFallingLevel, xcapDischargeDone,
      correctionLimit2, resonantOvercurrent} = flt;
   fss_sequencer #(.LONG_CYCLES(LG), .SHORT_CYCLES(SH), .MODE_READ_CYCLES(10)) dut
   (
      .sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .supplyStart(supplyStart), .selfbiasStartLevel(selfbiasStartLevel),
      .selfbiasStopLevel(selfbiasStopLevel), .auxbiasStopLevel(auxbiasStopLevel),
      .modeSelectHigh(modeSelectHigh), .correctionRunThreshold(correctionRunThreshold),
      .dualRunThreshold(dualRunThreshold),
      .lineCurrentRisingThreshold(lineCurrentRisingThreshold),
      .brownoutFallingLevel(brownoutFallingLevel), .lineOverRisingLevel(lineOverRisingLevel),
      .bulkBelowPeak(bulkBelowPeak), .shutdownTemperature(shutdownTemperature),
      .restartTemperature(restartTemperature), .resonantOvercurrent(resonantOvercurrent),
      .correctionLimit2(correctionLimit2), .xcapDischargeDone(xcapDischargeDone),
      .correctionStageEn(correctionStageEn), .resonantStageEn(resonantStageEn),
      .startupTransistorGate(startupTransistorGate), .selfBiasMode(selfBiasMode)
   );
   fss_power_partner pm
   (
      .sys_clk(sys_clk), .rst_b(rst_b), .supplyUp(supplyStart), .tiedHigh(tiedHigh),
      .runLevel(runLevel), .modeSelectHigh(modeSelectHigh),
      .correctionRunThreshold(correctionRunThreshold), .dualRunThreshold(dualRunThreshold)
   );
   // system clock
   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   task finalReport;
      if (miscompares == 0 && numChecks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      {psel, penable} <= 2'b00;
   endtask
   task rd(input logic [11:0] a, input logic [32:0] e);
      q.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask
   // lim of zero compares at once
   task waitSt(input logic p, input logic l, input int lim);
      int n;
      n = 0;
      while ({correctionStageEn, resonantStageEn} !== {p, l} && n < lim)
      begin
         @(posedge sys_clk);
         n++;
      end
      `CHK("stages", {p, l}, {correctionStageEn, resonantStageEn})
   endtask
   task pulse(input logic [5:0] m);
      @(posedge sys_clk);
      flt <= m;
      repeat (3 + $urandom % 5) @(posedge sys_clk);
      flt <= 6'h00;
   endtask
   task boot(input logic sb, input logic [31:0] c);
      @(posedge sys_clk);
      {rst_b, supplyStart, tiedHigh} <= {2'b00, sb};
      @(posedge sys_clk);
      rst_b <= 1'b1;
      apb(1'b1, `FSS_ADDR_CTRL, c);
      supplyStart <= 1'b1;
   endtask
   // read answers checked in order of issue
   always @(posedge sys_clk)
      if (psel && penable && pready === 1'b1 && !pwrite && q.size() > 0)
      begin
         ex = q.pop_front();
         `CHK("prdata", ex[31:0], prdata)
         `CHK("pslverr", ex[32], pslverr)
      end
   // main sequence
   initial
   begin
      {rst_b, psel, penable, pwrite, paddr, pwdata, supplyStart, tiedHigh, runLevel} = '0;
      {selfbiasStartLevel, selfbiasStopLevel, auxbiasStopLevel, bulkBelowPeak, flt} = '0;
      {lineCurrentRisingThreshold, restartTemperature} = 2'b11;
      k = $urandom(32'hc982);
      repeat (20) @(posedge sys_clk);
      rst_b <= 1'b1;
      rd(`FSS_ADDR_STATUS, 33'h040);
      rd(12'h00c, 33'h100000000);
      boot(1'b0, 32'h3);
      repeat (30) @(posedge sys_clk);
      `CHK("gate", 1'b0, startupTransistorGate)
      `CHK("mode", 1'b0, selfBiasMode)
      {auxbiasStopLevel, runLevel} <= 3'b101;
      waitSt(1'b1, 1'b0, 60);
      runLevel <= 2'h2;
      waitSt(1'b1, 1'b1, 20);
      for (k = 0; k < 5; k++)
      begin
         pulse(6'h01 << k);
         waitSt(1'b0, 1'b0, 12);
         repeat ((k < 3 ? LG : SH) - 10) @(posedge sys_clk);
         waitSt(1'b0, 1'b0, 0);
         waitSt(1'b1, 1'b1, 20);
      end
      pulse(6'h09);
      repeat (SH + 40) @(posedge sys_clk);
      waitSt(1'b0, 1'b0, 0);
      waitSt(1'b1, 1'b1, LG + 90);
      restartTemperature <= 1'b0;
      pulse(6'h20);
      waitSt(1'b0, 1'b0, 4);
      repeat (LG + 40) @(posedge sys_clk);
      waitSt(1'b0, 1'b0, 0);
      restartTemperature <= 1'b1;
      waitSt(1'b1, 1'b1, 90);
      rd(`FSS_ADDR_FAULT, 33'h00e);
      apb(1'b1, `FSS_ADDR_FAULT, 32'he);
      rd(`FSS_ADDR_FAULT, 33'h0);
      bulkBelowPeak <= 1'b1;
      repeat (20) @(posedge sys_clk);
      waitSt(1'b1, 1'b1, 0);
      {bulkBelowPeak, auxbiasStopLevel} <= 2'b00;
      waitSt(1'b0, 1'b0, 8);
      auxbiasStopLevel <= 1'b1;
      waitSt(1'b1, 1'b1, SH + 90);
      boot(1'b1, 32'h3);
      repeat (10) @(posedge sys_clk);
      `CHK("mode", 1'b1, selfBiasMode)
      `CHK("gate", 1'b1, startupTransistorGate)
      {selfbiasStopLevel, selfbiasStartLevel} <= 2'b11;
      waitSt(1'b1, 1'b1, 40);
      `CHK("gate", 1'b0, startupTransistorGate)
      {selfbiasStopLevel, selfbiasStartLevel} <= 2'b00;
      waitSt(1'b0, 1'b0, 8);
      repeat (SH + 20) @(posedge sys_clk);
      `CHK("gate", 1'b1, startupTransistorGate)
      {selfbiasStopLevel, selfbiasStartLevel} <= 2'b11;
      waitSt(1'b1, 1'b1, 90);
      // memory fail in aux, then bulk low at a self-bias turn-on
      for (k = 0; k < 2; k++)
      begin
         bulkBelowPeak <= k[0];
         boot(k[0], k ? 32'h3 : 32'h2);
         repeat (LG + 60) @(posedge sys_clk);
         waitSt(1'b0, 1'b0, 0);
         apb(1'b1, `FSS_ADDR_FAULT, 32'hf);
         repeat (30) @(posedge sys_clk);
         waitSt(1'b0, 1'b0, 0);
      end
      finalReport;
   end
   // hang guard, well past the expected run
   initial
   begin
      repeat (30000) @(posedge sys_clk);
      miscompares++;
      finalReport;
   end
endmodule
